// ---- bench/nsx_exec_checker.sv ----
`timescale 1ns/1ps
module nsx_exec_checker (
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        instr_valid_i,
	input wire logic [13:0] instr_i,
	input wire logic        ext_we_i,
	input wire logic [6:0]  ext_addr_i,
	input wire logic [7:0]  ext_wdata_i,
	input wire logic [7:0]  w_o,
	input wire logic        zero_o,
	input wire logic [7:0]  dir_a_o,
	input wire logic [7:0]  dir_b_o,
	input wire logic        illegal_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	wire sw = instr_valid_i && instr_i[13:8] == 6'h0E;
	wire xl = instr_valid_i && instr_i[13:8] == 6'h3A;
	wire xf = instr_valid_i && instr_i[13:8] == 6'h06;
	wire tr = instr_valid_i && instr_i[13:3] == 11'h00C;
	sequence port_direction_load_b; tr && instr_i[2:0] == 3'h6; endsequence
	sequence port_direction_load_bad; tr && instr_i[2:0] < 3'h5; endsequence
	a_swap_flags: assert property (sw |=> $stable(zero_o)) else $error("swap zero");
	a_swap_dest: assert property (sw && instr_i[7] |=> $stable(w_o)) else $error("swap dest");
	a_lit_value: assert property (xl |=> w_o == ($past(w_o) ^ $past(instr_i[7:0]))) else $error("lit xor");
	a_lit_zero: assert property (xl |=> zero_o == (w_o == 8'h00)) else $error("lit zero");
	a_dir_load: assert property (port_direction_load_b |=> dir_b_o == $past(w_o) && $stable(zero_o)) else $error("dir load");
	a_dir_bad: assert property (port_direction_load_bad |=> illegal_o && $stable(dir_b_o)) else $error("dir bad");
	a_dir_direct: assert property (ext_we_i && ext_addr_i == 7'h05 && !instr_valid_i
		|=> dir_a_o == $past(ext_wdata_i)) else $error("dir direct");
	a_file_zero: assert property (xf && !instr_i[7] |=> zero_o == (w_o == 8'h00)) else $error("file zero");
endmodule
bind nsx_exec nsx_exec_checker u_chk (.*);

// ---- bench/nsx_exec_tb.sv ----
`timescale 1ns/1ps
`define C(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module nsx_exec_tb;
	logic        clk_i, rstn_i, instr_valid_i, ext_we_i, zero_o, illegal_o;
	logic [13:0] instr_i;
	logic [6:0]  next_addr_i, ext_addr_i;
	logic [7:0]  ext_wdata_i, ext_rdata_o, w_o, dir_a_o, dir_b_o, dir_c_o;
	int          fail_count, checked;
	nsx_exec dut (.*);
	initial forever #2 clk_i = ~clk_i;
	// file read is registered, so the address leads by one cycle
	task automatic ex(input logic [13:0] ins, input logic [6:0] na);
		@(negedge clk_i) next_addr_i = na;
		@(negedge clk_i) {instr_i, instr_valid_i} = {ins, 1'b1};
		@(negedge clk_i) instr_valid_i = 1'b0;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_i) {ext_addr_i, ext_wdata_i, ext_we_i} = {a, d, 1'b1};
		@(negedge clk_i) ext_we_i = 1'b0;
		@(negedge clk_i);
	endtask
	task automatic finish_test;
		if (fail_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_swap;
		wr(7'h20, 8'hA5);
		ex(14'h0E20, 7'h20);
		`C("swap w", 8'h5A, w_o)
		ex(14'h0EA0, 7'h20);
		`C("swap f", 8'h5A, w_o)
		ex(14'h0620, 7'h20);
		`C("xor_file_op", 9'h100, {zero_o, w_o})
		ex(14'h0E20, 7'h20);
		`C("swap z", 9'h1A5, {zero_o, w_o})
	endtask
	task automatic t_xor;
		ex(14'h3AB5, 7'h20);
		`C("xor_literal_op", 9'h010, {zero_o, w_o})
		ex(14'h3A10, 7'h20);
		`C("xor_literal_op z", 9'h100, {zero_o, w_o})
		ex(14'h3AAF, 7'h20);
		`C("xor_literal_op nz", 9'h0AF, {zero_o, w_o})
	endtask
	task automatic t_dir;
		ex(14'h0066, 7'h20);
		`C("dir load", 9'h15E, {dir_b_o, zero_o})
		ex(14'h0063, 7'h20);
		`C("bad sel", 9'h15F, {dir_b_o, illegal_o})
		wr(7'h05, 8'h3C);
		`C("dir wr", 16'h3C3C, {dir_a_o, ext_rdata_o})
		ex(14'h0E05, 7'h05);
		`C("dir rd", 8'hC3, w_o)
	endtask
	task automatic t_more;
		ex(14'h0065, 7'h20);
		ex(14'h0067, 7'h20);
		`C("dir a c", 16'hC3C3, {dir_a_o, dir_c_o})
		ex(14'h0686, 7'h06);
		`C("xor_file_op dir", 17'h0D8C3, {dir_b_o, zero_o, w_o})
		wr(7'h21, 8'hC3);
		ex(14'h06A1, 7'h21);
		`C("xor_file_op f", 9'h1C3, {zero_o, w_o})
		ex(14'h0E21, 7'h21);
		`C("xor_file_op f rd", 9'h100, {zero_o, w_o})
		@(negedge clk_i) ext_addr_i = 7'h07;
		@(negedge clk_i);
		`C("dir c rd", 8'hC3, ext_rdata_o)
	endtask
	initial begin
		{clk_i, rstn_i, instr_valid_i, ext_we_i, instr_i} = 18'h00000;
		{next_addr_i, ext_addr_i, ext_wdata_i} = {7'h00, 7'h05, 8'h00};
		fail_count = 0;
		checked = 0;
		repeat (6) @(negedge clk_i);
		rstn_i = 1'b1;
		`C("reset", 41'h0FFFFFFFF, {w_o, zero_o, dir_a_o, dir_b_o, dir_c_o, ext_rdata_o})
		t_swap();
		t_xor();
		t_dir();
		t_more();
		finish_test();
	end
	initial begin
		#2000;
		fail_count++;
		finish_test();
	end
endmodule

// ---- rtl/nsx_exec.sv ----
// Behaviour
// - nibble exchange swaps f nibbles, flags untouched
// - nibble exchange: d=0 to W, d=1 to f
// - literal XOR: W xor k into W
// - literal XOR sets only zero flag
// - direction load copies W to direction reg 5-7
// - direction regs reachable as ordinary file registers
`timescale 1ns/1ps
module nsx_exec (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        instr_valid_i,
	input  wire logic [13:0] instr_i,
	input  wire logic [6:0]  next_addr_i,
	input  wire logic        ext_we_i,
	input  wire logic [6:0]  ext_addr_i,
	input  wire logic [7:0]  ext_wdata_i,
	output logic      [7:0]  ext_rdata_o,
	output logic      [7:0]  w_o,
	output logic             zero_o,
	output logic      [7:0]  dir_a_o,
	output logic      [7:0]  dir_b_o,
	output logic      [7:0]  dir_c_o,
	output logic             illegal_o
);
	// ************************************************************
	// decode
	// ************************************************************
	logic [7:0]  w_ff;
	logic        zero_ff;
	logic [7:0]  dir_ff [nsx_pkg::DIR_REGS];
	logic        illegal_ff;
	logic [7:0]  ext_rdata_ff;
	logic [7:0]  mem_rdata;
	logic [7:0]  file_val;
	logic [6:0]  f_addr;
	logic        dest_f;
	logic        is_swap;
	logic        is_xorf;
	logic        is_xorl;
	logic        is_dir;
	logic        dir_ok;
	logic [1:0]  dir_idx;
	logic        f_is_dir;
	logic [1:0]  f_dir_idx;
	logic [7:0]  result;
	logic        file_we;
	logic        mem_we;
	logic [6:0]  mem_waddr;
	logic [7:0]  mem_wdata;

	typedef enum logic [2:0] {
		NSX_OP_NONE = 3'h0,
		NSX_OP_SWAP = 3'h1,
		NSX_OP_XORF = 3'h2,
		NSX_OP_XORL = 3'h3,
		NSX_OP_DIR  = 3'h4
	} nsx_op_t;

	nsx_op_t     op_kind;
	logic [1:0]  opc_hi;
	logic [3:0]  opc_field;
	logic        w_we;
	logic        zero_we;
	logic        ext_is_dir;
	logic [1:0]  ext_dir_idx;

	assign f_addr    = instr_i[6:0];
	assign dest_f    = instr_i[nsx_pkg::DEST_POS];
	assign opc_hi    = instr_i[nsx_pkg::OPC_HI_POS +: 2];
	assign opc_field = instr_i[nsx_pkg::OPC_FIELD_POS +: 4];

	// the wider literal and direction-load codes are matched first
	always_comb begin
		op_kind = NSX_OP_NONE;
		if (instr_valid_i) begin
			if (instr_i[13:8] == nsx_pkg::OP_XOR_LIT) begin
				op_kind = NSX_OP_XORL;
			end else if (instr_i[13:3] == nsx_pkg::OP_DIR_LOAD) begin
				op_kind = NSX_OP_DIR;
			end else if (opc_hi == 2'h0 && opc_field == nsx_pkg::OP_NIBBLE_EXCH) begin
				op_kind = NSX_OP_SWAP;
			end else if (opc_hi == 2'h0 && opc_field == nsx_pkg::OP_XOR_FILE) begin
				op_kind = NSX_OP_XORF;
			end
		end
	end

	assign is_swap = op_kind == NSX_OP_SWAP;
	assign is_xorf = op_kind == NSX_OP_XORF;
	assign is_xorl = op_kind == NSX_OP_XORL;
	assign is_dir  = op_kind == NSX_OP_DIR;
	assign dir_ok  = instr_i[2:0] >= nsx_pkg::DIR_SEL_MIN;
	assign dir_idx = 2'(instr_i[2:0] - nsx_pkg::DIR_SEL_MIN);

	assign ext_is_dir  = ext_addr_i >= nsx_pkg::ADDR_DIR_A
		&& ext_addr_i < nsx_pkg::ADDR_DIR_A + 7'(nsx_pkg::DIR_REGS);
	assign ext_dir_idx = 2'(ext_addr_i - nsx_pkg::ADDR_DIR_A);

	// direction regs overlay file addresses 5..7
	assign f_is_dir  = f_addr >= nsx_pkg::ADDR_DIR_A
		&& f_addr < nsx_pkg::ADDR_DIR_A + 7'(nsx_pkg::DIR_REGS);
	assign f_dir_idx = 2'(f_addr - nsx_pkg::ADDR_DIR_A);
	assign file_val  = f_is_dir ? dir_ff[f_dir_idx] : mem_rdata;

	// ************************************************************
	// execute
	// ************************************************************
	always_comb begin
		result = w_ff;
		if (is_swap) begin
			result = {file_val[3:0], file_val[7:4]};
		end else if (is_xorf) begin
			result = w_ff ^ file_val;
		end else if (is_xorl) begin
			result = w_ff ^ instr_i[7:0];
		end
	end

	// ************************************************************
	// write enables
	// ************************************************************
	always_comb begin
		w_we    = 1'b0;
		zero_we = 1'b0;
		file_we = 1'b0;
		unique case (op_kind)
			NSX_OP_SWAP: begin
				w_we    = !dest_f;
				file_we = dest_f;
			end
			NSX_OP_XORF: begin
				w_we    = !dest_f;
				file_we = dest_f;
				zero_we = 1'b1;
			end
			NSX_OP_XORL: begin
				w_we    = 1'b1;
				zero_we = 1'b1;
			end
			NSX_OP_DIR, NSX_OP_NONE: begin
				w_we = 1'b0;
			end
		endcase
	end

	// instruction write wins over an external write in the same cycle
	assign mem_we    = (file_we && !f_is_dir) || (ext_we_i && !file_we);
	assign mem_waddr = file_we ? f_addr : ext_addr_i;
	assign mem_wdata = file_we ? result : ext_wdata_i;

	// ************************************************************
	// file memory
	// ************************************************************
	nsx_file_mem #(
		.DEPTH (nsx_pkg::FILE_DEPTH),
		.AW    (7)
	) u_mem (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.raddr_i (next_addr_i),
		.rdata_o (mem_rdata),
		.we_i    (mem_we),
		.waddr_i (mem_waddr),
		.wdata_i (mem_wdata)
	);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			w_ff <= nsx_pkg::RST_W;
		end else if (w_we) begin
			w_ff <= result;
		end
	end

	// swap and direction load leave the flag alone
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			zero_ff <= 1'b0;
		end else if (zero_we) begin
			zero_ff <= (result == 8'h00);
		end
	end

	generate
		for (genvar i = 0; i < nsx_pkg::DIR_REGS; i++) begin : g_dir
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					dir_ff[i] <= nsx_pkg::RST_DIR;
				end else if (is_dir && dir_ok && dir_idx == 2'(i)) begin
					dir_ff[i] <= w_ff;
				end else if (file_we && f_is_dir && f_dir_idx == 2'(i)) begin
					dir_ff[i] <= result;
				end else if (!file_we && ext_we_i && ext_is_dir && ext_dir_idx == 2'(i)) begin
					dir_ff[i] <= ext_wdata_i;
				end
			end
		end
	endgenerate

	// direction load with selector below 5 is reported, not executed
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			illegal_ff <= 1'b0;
		end else begin
			illegal_ff <= is_dir && !dir_ok;
		end
	end

	// external read of the direction overlay, registered
	// outside 5..7 the last value is held instead of indexing past the array
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ext_rdata_ff <= nsx_pkg::RST_DIR;
		end else if (ext_is_dir) begin
			ext_rdata_ff <= dir_ff[ext_dir_idx];
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign ext_rdata_o = ext_rdata_ff;
	assign w_o         = w_ff;
	assign zero_o      = zero_ff;
	assign dir_a_o     = dir_ff[0];
	assign dir_b_o     = dir_ff[1];
	assign dir_c_o     = dir_ff[2];
	assign illegal_o   = illegal_ff;
endmodule

// ---- rtl/nsx_file_mem.sv ----
`timescale 1ns/1ps
module nsx_file_mem #(
	parameter int DEPTH = 128,
	parameter int AW    = 7
) (
	input  wire logic          clk_i,
	input  wire logic          rstn_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic      [7:0]    rdata_o,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [7:0]    wdata_i
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// registered read: address must be presented one cycle before use
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= nsx_pkg::RST_FILE;
		end else begin
			rdata_o <= (we_i && waddr_i == raddr_i) ? wdata_i : mem[raddr_i];
		end
	end
endmodule

// ---- rtl/nsx_pkg.sv ----
package nsx_pkg;
	// ************************************************************
	// opcode fields
	// ************************************************************
	localparam logic [13:0] OPC_W            = 14'h0000;
	localparam logic [3:0]  OP_NIBBLE_EXCH   = 4'hE;
	localparam logic [3:0]  OP_XOR_FILE      = 4'h6;
	localparam logic [5:0]  OP_XOR_LIT       = 6'h3A;
	localparam logic [10:0] OP_DIR_LOAD      = 11'h00C;
	localparam int          OPC_HI_POS       = 12;
	localparam int          OPC_FIELD_POS    = 8;
	localparam int          DEST_POS         = 7;
	localparam logic [2:0]  DIR_SEL_MIN      = 3'h5;
	localparam logic [2:0]  DIR_SEL_MAX      = 3'h7;
	// ************************************************************
	// file map
	// ************************************************************
	localparam logic [6:0]  ADDR_DIR_A       = 7'h05;
	localparam int          DIR_REGS         = 3;
	localparam logic [7:0]  RST_W            = 8'h00;
	localparam logic [7:0]  RST_DIR          = 8'hFF;
	localparam logic [7:0]  RST_FILE         = 8'h00;
	localparam int          FILE_DEPTH       = 128;
endpackage
